// ==== hw/byte_fifo.sv ====
// Purpose: Small flip-flop FIFO with valid and ready on both sides
// Assumes: DEPTH is at least two
// Notes: Flags are registered so ready and valid come from flip-flops
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr;
  logic [PW-1:0] rd;
  logic [PW:0] count;
  logic [PW:0] next_count;
  logic push;
  logic pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd];

  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr] <= i_in_data;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr <= '0;
      rd <= '0;
      count <= '0;
      o_in_ready <= 1'b0;
      o_out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr <= (wr == PTR_LAST) ? '0 : wr + 1'b1;
      if (pop)
        rd <= (rd == PTR_LAST) ? '0 : rd + 1'b1;
      count <= next_count;
      o_in_ready <= next_count != FULL;
      o_out_valid <= next_count != '0;
    end
  end
endmodule // byte_fifo

// ==== hw/ip_auth_command_engine.sv ====
// Purpose: Interpreter of the IP authentication command, card side
// Assumes: Hash engine and secret store sit outside on the same clock
// Notes: Hash bytes are streamed out; the digest comes back whole
module ip_auth_command_engine
  import ip_auth_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic I_CMD_VALID,
  input wire logic [7:0] I_CLA,
  input wire logic [7:0] I_INS,
  input wire logic [7:0] I_P1,
  input wire logic [7:0] I_P2,
  input wire logic [7:0] I_LC,
  output logic O_CMD_READY,
  input wire logic I_DATA_VALID,
  input wire logic [7:0] I_DATA,
  output logic O_DATA_READY,
  input wire logic I_HASH_ALG,
  output logic O_HASH_ALG,
  output logic O_HASH_VALID,
  output logic [7:0] O_HASH_BYTE,
  output logic O_HASH_FIRST,
  output logic O_HASH_FINISH,
  input wire logic I_HASH_READY,
  input wire logic I_HASH_DONE,
  input wire logic [127:0] I_HASH_DIGEST,
  output logic [1:0] O_SECRET_BANK,
  output logic [7:0] O_PROFILE_INDEX,
  input wire logic [127:0] I_SECRET,
  output logic O_RSP_VALID,
  output logic [7:0] O_RSP_LEN,
  output logic [127:0] O_RSP_DATA,
  output logic [7:0] O_SW1,
  output logic [7:0] O_SW2
);
  state_t state;
  state_t next_state;
  seq_t seq;
  seq_t next_seq;
  ctl_t ctl;
  ctl_t next_ctl;
  logic [7:0] cnt;
  logic [7:0] body_left;
  logic [7:0] hi;
  logic [127:0] retained;
  logic first_pend;
  logic f_valid;
  logic [7:0] f_data;
  logic accept;
  logic slot;
  logic have;
  logic feed;
  logic pop;
  logic step;
  logic [7:0] src_byte;
  logic chain_first;
  logic chain_end;
  logic p1_bad;
  logic p2_bad;
  logic seq_err;
  logic dec_err;
  logic [7:0] min_lc;
  logic [7:0] dec_sw1;
  logic [7:0] dec_sw2;

  byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(I_CLK_SYS),
    .i_nrst(I_NRST),
    .i_in_valid(I_DATA_VALID),
    .i_in_data(I_DATA),
    .o_in_ready(O_DATA_READY),
    .o_out_valid(f_valid),
    .o_out_data(f_data),
    .i_out_ready(pop)
  );

  assign accept = (state == ST_IDLE) && O_CMD_READY && I_CMD_VALID;
  assign slot = !O_HASH_VALID || I_HASH_READY;

  // Command decode and sequence check
  always_comb
  begin
    next_ctl = '0;
    next_seq = seq;
    seq_err = 1'b0;
    p1_bad = 1'b0;
    chain_first = (I_P2 == P2_FIRST) || (I_P2 == P2_SINGLE);
    chain_end = (I_P2 == P2_SINGLE) || (I_P2 == P2_LAST);
    p2_bad = I_P2 != P2_FIRST;
    case (I_P1)
      P1_CHAP:
      begin
        next_ctl.npre = NPRE_TWO;
        next_ctl.feed0 = 1'b1;
        next_ctl.idx1 = 1'b1;
        next_ctl.sec1 = 1'b1;
        next_ctl.first = 1'b1;
        next_ctl.fin = 1'b1;
        next_ctl.rsp16 = 1'b1;
        next_ctl.bank = BANK_SIMPLE;
      end
      P1_HA:
      begin
        p2_bad = I_P2 > P2_LAST;
        next_ctl.npre = chain_first ? NPRE_ONE : NPRE_NONE;
        next_ctl.idx0 = chain_first;
        next_ctl.sec1 = chain_first;
        next_ctl.first = chain_first;
        next_ctl.sec2 = chain_end;
        next_ctl.fin = chain_end;
        next_ctl.rsp16 = chain_end;
        next_ctl.bank = BANK_HOME;
        // Repeats allowed from any state without an open chain
        seq_err = chain_first ? (seq == SEQ_HA_OPEN || seq == SEQ_RRQ_OPEN)
                              : (seq != SEQ_HA_OPEN);
        next_seq = chain_end ? SEQ_HA_DONE : SEQ_HA_OPEN;
      end
      P1_RRQ:
      begin
        p2_bad = I_P2 > P2_LAST;
        next_ctl.first = chain_first;
        next_ctl.fin = chain_end;
        next_ctl.retain = chain_end;
        seq_err = chain_first ? (seq != SEQ_HA_DONE) : (seq != SEQ_RRQ_OPEN);
        next_seq = chain_end ? SEQ_RRQ_DONE : SEQ_RRQ_OPEN;
      end
      P1_AAA:
      begin
        next_ctl.npre = NPRE_TWO;
        next_ctl.idx0 = 1'b1;
        next_ctl.feed1 = 1'b1;
        next_ctl.sec1 = 1'b1;
        next_ctl.mid = 1'b1;
        next_ctl.hi2 = I_LC <= AAA_SHORT_MAX_LC;
        next_ctl.first = 1'b1;
        next_ctl.fin = 1'b1;
        next_ctl.rsp16 = 1'b1;
        next_ctl.bank = BANK_AAA;
        seq_err = seq != SEQ_RRQ_DONE;
        next_seq = SEQ_IDLE;
      end
      P1_HRPD:
      begin
        next_ctl.npre = NPRE_ONE;
        next_ctl.feed0 = 1'b1;
        next_ctl.sec1 = 1'b1;
        next_ctl.first = 1'b1;
        next_ctl.fin = 1'b1;
        next_ctl.rsp16 = 1'b1;
        next_ctl.bank = BANK_HRPD;
      end
      default:
        p1_bad = 1'b1;
    endcase
    min_lc = {6'h00, next_ctl.npre} + ((I_P1 == P1_RRQ && chain_end) ? RRQ_EXT_LEN : 8'h00);
    dec_sw2 = SW2_NONE;
    if (I_CLA != CLA_IP)
      dec_sw1 = SW1_CLA;
    else if (I_INS != INS_IP)
      dec_sw1 = SW1_INS;
    else if (p1_bad || p2_bad)
      dec_sw1 = SW1_PARAM;
    else if (I_LC < min_lc)
      dec_sw1 = SW1_LEN;
    else if (seq_err)
    begin
      dec_sw1 = SW1_SEQ;
      dec_sw2 = SW2_SEQ;
    end
    else
      dec_sw1 = SW1_OK;
    dec_err = dec_sw1 != SW1_OK;
    if (dec_sw1 == SW1_SEQ)
      next_seq = SEQ_IDLE;
    else if (dec_err)
      next_seq = seq;
  end

  // Byte source for the hash stream
  always_comb
  begin
    have = 1'b0;
    feed = 1'b0;
    pop = 1'b0;
    src_byte = f_data;
    case (state)
      ST_PRE:
      begin
        have = f_valid;
        feed = (cnt == 8'h00) ? ctl.feed0 : ctl.feed1;
        pop = slot && f_valid;
      end
      ST_SEC1, ST_SEC2:
      begin
        have = 1'b1;
        feed = 1'b1;
        src_byte = I_SECRET[{~cnt[3:0], 3'b000} +: 8];
      end
      ST_MID:
      begin
        have = 1'b1;
        feed = 1'b1;
        // Short challenge gets its high byte a second time
        src_byte = (cnt == MID_HI_POS) ? hi : retained[{~cnt[3:0], 3'b000} +: 8];
      end
      ST_BODY:
      begin
        have = f_valid;
        feed = 1'b1;
        pop = slot && f_valid;
      end
      ST_DRAIN:
        pop = f_valid;
      default:
      begin
        have = 1'b0;
      end
    endcase
    step = slot && have;
  end

  function automatic state_t follow(input state_t s);
    state_t n;
    n = ST_FLUSH;
    if (s == ST_START && ctl.npre != NPRE_NONE)
      n = ST_PRE;
    else if (s inside {ST_START, ST_PRE} && ctl.sec1)
      n = ST_SEC1;
    else if (s inside {ST_START, ST_PRE, ST_SEC1} && ctl.mid)
      n = ST_MID;
    else if (s inside {ST_START, ST_PRE, ST_SEC1, ST_MID} && body_left != 8'h00)
      n = ST_BODY;
    else if (s != ST_SEC2 && ctl.sec2)
      n = ST_SEC2;
    return n;
  endfunction

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (accept)
          next_state = !dec_err ? ST_START : (I_LC == 8'h00) ? ST_FLUSH : ST_DRAIN;
      ST_START:
        next_state = follow(ST_START);
      ST_PRE:
        if (step && (cnt[1:0] + 2'h1) == ctl.npre)
          next_state = follow(ST_PRE);
      ST_SEC1:
        if (step && cnt == SECRET_LAST)
          next_state = follow(ST_SEC1);
      ST_MID:
        if (step && cnt == (ctl.hi2 ? MID_HI_POS : SECRET_LAST))
          next_state = follow(ST_MID);
      ST_BODY:
        if (step && body_left == 8'h01)
          next_state = follow(ST_BODY);
      ST_SEC2:
        if (step && cnt == SECRET_LAST)
          next_state = ST_FLUSH;
      ST_FLUSH:
        if (!O_HASH_VALID)
          next_state = (ctl.fin && O_SW1 == SW1_OK) ? ST_WAIT : ST_IDLE;
      ST_WAIT:
        if (I_HASH_DONE)
          next_state = ST_IDLE;
      ST_DRAIN:
        if (f_valid && cnt == 8'h01)
          next_state = ST_FLUSH;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      state <= ST_IDLE;
      O_CMD_READY <= 1'b0;
    end
    else
    begin
      state <= next_state;
      O_CMD_READY <= next_state == ST_IDLE;
    end
  end

  // Position counter within a stage, or bytes left to drain
  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
      cnt <= 8'h00;
    else if (next_state != state)
      cnt <= (next_state == ST_DRAIN) ? I_LC : 8'h00;
    else if (state == ST_DRAIN && pop)
      cnt <= cnt - 8'h01;
    else if (step)
      cnt <= cnt + 8'h01;
  end

  // Block length fits the 8-bit count; the host keeps blocks short
  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
      body_left <= 8'h00;
    else if (accept)
      body_left <= I_LC - {6'h00, next_ctl.npre};
    else if (state == ST_BODY && step)
      body_left <= body_left - 8'h01;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      ctl <= '0;
      O_SECRET_BANK <= BANK_SIMPLE;
      O_PROFILE_INDEX <= 8'h00;
      hi <= 8'h00;
    end
    else
    begin
      if (accept && !dec_err)
      begin
        ctl <= next_ctl;
        O_SECRET_BANK <= next_ctl.bank;
      end
      if (state == ST_PRE && step && (cnt == 8'h00 ? ctl.idx0 : ctl.idx1))
        O_PROFILE_INDEX <= f_data;
      if (state == ST_PRE && step && cnt != 8'h00 && ctl.mid)
        hi <= f_data;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      seq <= SEQ_IDLE;
      retained <= '0;
    end
    else
    begin
      if (accept)
        seq <= next_seq;
      if (accept && dec_sw1 == SW1_SEQ)
        retained <= '0;
      else if (state == ST_WAIT && I_HASH_DONE && ctl.retain)
        retained <= I_HASH_DIGEST;
    end
  end

  // Hash byte stream and engine control
  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_HASH_VALID <= 1'b0;
      O_HASH_BYTE <= 8'h00;
      O_HASH_FIRST <= 1'b0;
      O_HASH_FINISH <= 1'b0;
      O_HASH_ALG <= 1'b0;
      first_pend <= 1'b0;
    end
    else
    begin
      if (step)
      begin
        O_HASH_VALID <= feed;
        if (feed)
        begin
          O_HASH_BYTE <= src_byte;
          O_HASH_FIRST <= first_pend;
        end
      end
      else if (slot)
        O_HASH_VALID <= 1'b0;
      if (accept && !dec_err && next_ctl.first)
      begin
        first_pend <= 1'b1;
        O_HASH_ALG <= I_HASH_ALG;
      end
      else if (step && feed)
        first_pend <= 1'b0;
      O_HASH_FINISH <= state == ST_FLUSH && next_state == ST_WAIT;
    end
  end

  // Status word and response data
  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_RSP_VALID <= 1'b0;
      O_RSP_LEN <= RSP_LEN_NONE;
      O_RSP_DATA <= '0;
      O_SW1 <= SW1_OK;
      O_SW2 <= SW2_NONE;
    end
    else
    begin
      O_RSP_VALID <= state != ST_IDLE && next_state == ST_IDLE;
      if (accept)
      begin
        O_SW1 <= dec_sw1;
        O_SW2 <= dec_sw2;
        O_RSP_LEN <= RSP_LEN_NONE;
        O_RSP_DATA <= '0;
      end
      else if (state == ST_WAIT && I_HASH_DONE && ctl.rsp16)
      begin
        O_RSP_LEN <= RSP_LEN_DIGEST;
        O_RSP_DATA <= I_HASH_DIGEST;
      end
    end
  end
endmodule // ip_auth_command_engine

// ==== hw/ip_auth_pkg.sv ====
// Purpose: Shared constants and types of the IP authentication command engine
// Assumes: One system clock, byte-wide command data
// Notes: Status words and field codes are named once here
package ip_auth_pkg;
  localparam logic [7:0] CLA_IP = 8'h80;
  localparam logic [7:0] INS_IP = 8'h80;
  localparam logic [7:0] P1_CHAP = 8'h00;
  localparam logic [7:0] P1_HA = 8'h01;
  localparam logic [7:0] P1_RRQ = 8'h02;
  localparam logic [7:0] P1_AAA = 8'h03;
  localparam logic [7:0] P1_HRPD = 8'h04;
  localparam logic [7:0] P2_FIRST = 8'h00;
  localparam logic [7:0] P2_NEXT = 8'h01;
  localparam logic [7:0] P2_SINGLE = 8'h02;
  localparam logic [7:0] P2_LAST = 8'h03;
  localparam logic [7:0] SW1_OK = 8'h90;
  localparam logic [7:0] SW1_SEQ = 8'h98;
  localparam logic [7:0] SW2_SEQ = 8'h34;
  localparam logic [7:0] SW1_PARAM = 8'h6b;
  localparam logic [7:0] SW1_LEN = 8'h67;
  localparam logic [7:0] SW1_INS = 8'h6d;
  localparam logic [7:0] SW1_CLA = 8'h6e;
  localparam logic [7:0] SW2_NONE = 8'h00;
  localparam logic [7:0] RSP_LEN_NONE = 8'h00;
  localparam logic [7:0] RSP_LEN_DIGEST = 8'h10;
  localparam logic [7:0] SECRET_LAST = 8'h0f;
  localparam logic [7:0] MID_HI_POS = 8'h10;
  localparam logic [7:0] RRQ_EXT_LEN = 8'h08;
  localparam logic [7:0] AAA_SHORT_MAX_LC = 8'hee;
  localparam logic [1:0] NPRE_NONE = 2'h0;
  localparam logic [1:0] NPRE_ONE = 2'h1;
  localparam logic [1:0] NPRE_TWO = 2'h2;
  localparam logic [1:0] BANK_SIMPLE = 2'h0;
  localparam logic [1:0] BANK_HOME = 2'h1;
  localparam logic [1:0] BANK_AAA = 2'h2;
  localparam logic [1:0] BANK_HRPD = 2'h3;
  localparam int BYTE_W = 8;
  localparam int DIGEST_W = 128;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_START = 10'h002,
    ST_PRE = 10'h004,
    ST_SEC1 = 10'h008,
    ST_MID = 10'h010,
    ST_BODY = 10'h020,
    ST_SEC2 = 10'h040,
    ST_FLUSH = 10'h080,
    ST_WAIT = 10'h100,
    ST_DRAIN = 10'h200
  } state_t;

  typedef enum logic [5:0] {
    SEQ_IDLE = 6'h01,
    SEQ_HA_OPEN = 6'h02,
    SEQ_HA_DONE = 6'h04,
    SEQ_RRQ_OPEN = 6'h08,
    SEQ_RRQ_DONE = 6'h10,
    SEQ_SPARE = 6'h20
  } seq_t;

  typedef struct packed {
    logic [1:0] npre;
    logic feed0;
    logic feed1;
    logic idx0;
    logic idx1;
    logic sec1;
    logic mid;
    logic hi2;
    logic sec2;
    logic first;
    logic fin;
    logic rsp16;
    logic retain;
    logic [1:0] bank;
  } ctl_t;
endpackage

// ==== tb/hash_partner.sv ====
// Purpose: Hash engine and secret store facing the command engine
// Assumes: A rotate-and-xor digest stands in for the one-way hash
// Notes: Ready stalls at random; digest is scrambled outside its pulse
module hash_partner (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_first,
  input wire logic i_finish,
  input wire logic i_alg,
  input wire logic [1:0] i_bank,
  input wire logic [7:0] i_index,
  output logic o_ready,
  output logic o_done,
  output logic [127:0] o_digest,
  output logic [127:0] o_secret
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [127:0] acc;
  logic [127:0] base;
  logic [127:0] result;
  logic [31:0] lfsr;
  logic [2:0] wait_cnt;
  assign o_secret = {16{i_bank, i_index[5:0]}};
  assign o_digest = o_done ? result : ~result;
  assign base = i_first ? 128'h0 : acc;
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      acc <= '0;
      result <= '0;
      lfsr <= 32'h1d3;
      wait_cnt <= 3'h0;
      o_ready <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      o_ready <= lfsr[0] | lfsr[3];
      o_done <= (wait_cnt == 3'h1);
      if (wait_cnt != 3'h0)
        wait_cnt <= wait_cnt - 3'h1;
      if (i_finish)
        wait_cnt <= 3'h4;
      if (wait_cnt == 3'h1)
        result <= i_alg ? ~acc : acc;
      if (i_valid && o_ready)
        acc <= {base[119:0], base[127:120] ^ i_byte};
    end
endmodule // hash_partner

// ==== tb/ip_auth_command_engine_props.sv ====
// Purpose: Port-level checks of the IP authentication command engine
// Assumes: One clock domain, reset active low
// Notes: Bound onto every instance of the engine
module ip_auth_command_engine_props
  import ip_auth_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic I_CMD_VALID,
  input wire logic [7:0] I_CLA,
  input wire logic [7:0] I_INS,
  input wire logic [7:0] I_P1,
  input wire logic [7:0] I_P2,
  input wire logic [7:0] I_LC,
  input wire logic O_CMD_READY,
  input wire logic O_HASH_VALID,
  input wire logic [7:0] O_HASH_BYTE,
  input wire logic O_HASH_FIRST,
  input wire logic I_HASH_READY,
  input wire logic I_HASH_DONE,
  input wire logic [127:0] I_HASH_DIGEST,
  input wire logic O_RSP_VALID,
  input wire logic [7:0] O_RSP_LEN,
  input wire logic [127:0] O_RSP_DATA,
  input wire logic [7:0] O_SW1,
  input wire logic [7:0] O_SW2
);
  logic take;
  logic [7:0] last_op;
  logic [7:0] last_chain;
  logic [127:0] last_digest;
  assign take = I_CMD_VALID && O_CMD_READY;
  // Remembers the command in flight and the latest digest
  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
    if (!I_NRST)
    begin
      last_op <= 8'h00;
      last_chain <= 8'h00;
      last_digest <= '0;
    end
    else
    begin
      if (take)
      begin
        last_op <= I_P1;
        last_chain <= I_P2;
      end
      if (I_HASH_DONE)
        last_digest <= I_HASH_DIGEST;
    end
  default clocking @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_NRST);
  AST_CLASS_REJECT: assert property (take && I_CLA != CLA_IP && I_LC == 8'h00
    |-> ##2 O_RSP_VALID && O_SW1 == SW1_CLA) else $error("class byte not rejected");
  AST_OP_REJECT: assert property (take && I_CLA == CLA_IP && I_INS == INS_IP
    && I_P1 > P1_HRPD && I_LC == 8'h00 |-> ##2 O_RSP_VALID && O_SW1 == SW1_PARAM)
    else $error("unknown operation not rejected");
  AST_SEQ_WORD: assert property (O_RSP_VALID && O_SW1 == SW1_SEQ
    |-> O_SW2 == SW2_SEQ && O_RSP_LEN == RSP_LEN_NONE) else $error("bad sequence status");
  AST_RSP_LEN: assert property (O_RSP_VALID && O_SW1 == SW1_OK
    |-> O_RSP_LEN == ((last_op == P1_RRQ || (last_op == P1_HA && last_chain < P2_SINGLE))
    ? RSP_LEN_NONE : RSP_LEN_DIGEST)) else $error("response length wrong for operation");
  AST_RSP_DIGEST: assert property (O_RSP_VALID && O_RSP_LEN == RSP_LEN_DIGEST
    |-> O_RSP_DATA == last_digest) else $error("response is not the latest digest");
  AST_EMPTY_DATA: assert property (O_RSP_VALID && O_RSP_LEN == RSP_LEN_NONE
    |-> O_RSP_DATA == '0) else $error("data returned with zero length");
  AST_BYTE_HOLD: assert property (O_HASH_VALID && !I_HASH_READY
    |=> O_HASH_VALID && $stable(O_HASH_BYTE) && $stable(O_HASH_FIRST))
    else $error("hash byte changed before acceptance");
  AST_RSP_PULSE: assert property (O_RSP_VALID |=> !O_RSP_VALID)
    else $error("response valid longer than one cycle");
  AST_TAKE_BUSY: assert property (take |=> !O_CMD_READY
    ##1 ($past(I_LC, 2) == 8'h00 || !O_CMD_READY)) else $error("ready while a command runs");
endmodule // ip_auth_command_engine_props

bind ip_auth_command_engine ip_auth_command_engine_props props_i (
  .I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_CMD_VALID(I_CMD_VALID), .I_CLA(I_CLA),
  .I_INS(I_INS), .I_P1(I_P1), .I_P2(I_P2), .I_LC(I_LC), .O_CMD_READY(O_CMD_READY),
  .O_HASH_VALID(O_HASH_VALID), .O_HASH_BYTE(O_HASH_BYTE), .O_HASH_FIRST(O_HASH_FIRST),
  .I_HASH_READY(I_HASH_READY), .I_HASH_DONE(I_HASH_DONE), .I_HASH_DIGEST(I_HASH_DIGEST),
  .O_RSP_VALID(O_RSP_VALID), .O_RSP_LEN(O_RSP_LEN), .O_RSP_DATA(O_RSP_DATA),
  .O_SW1(O_SW1), .O_SW2(O_SW2)
);

// ==== tb/tb_ip_auth_command_engine.sv ====
// Purpose: Self-checking bench of the IP authentication command engine
// Assumes: Partner model answers hash and secret lookups
// Notes: Random data from a fixed xorshift seed
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module tb_ip_auth_command_engine import ip_auth_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic I_CLK_SYS = 1'b0;
  logic I_NRST, I_CMD_VALID, I_DATA_VALID, I_HASH_ALG, I_HASH_READY, I_HASH_DONE;
  logic [7:0] I_CLA, I_INS, I_P1, I_P2, I_LC, I_DATA, O_HASH_BYTE, O_PROFILE_INDEX;
  logic O_CMD_READY, O_DATA_READY, O_HASH_ALG, O_HASH_VALID, O_HASH_FIRST, O_HASH_FINISH;
  logic [127:0] I_HASH_DIGEST, I_SECRET, O_RSP_DATA, kept;
  logic [1:0] O_SECRET_BANK;
  logic O_RSP_VALID, al, full_seen;
  logic [7:0] O_RSP_LEN, O_SW1, O_SW2, ix, id;
  logic [31:0] seed = 32'ha755;
  logic [7:0] dq[$];
  logic [7:0] eq[$];
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 I_CLK_SYS = ~I_CLK_SYS;
  ip_auth_command_engine uut (.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST),
    .I_CMD_VALID(I_CMD_VALID), .I_CLA(I_CLA), .I_INS(I_INS), .I_P1(I_P1), .I_P2(I_P2),
    .I_LC(I_LC), .O_CMD_READY(O_CMD_READY), .I_DATA_VALID(I_DATA_VALID), .I_DATA(I_DATA),
    .O_DATA_READY(O_DATA_READY), .I_HASH_ALG(I_HASH_ALG), .O_HASH_ALG(O_HASH_ALG),
    .O_HASH_VALID(O_HASH_VALID), .O_HASH_BYTE(O_HASH_BYTE), .O_HASH_FIRST(O_HASH_FIRST),
    .O_HASH_FINISH(O_HASH_FINISH), .I_HASH_READY(I_HASH_READY), .I_HASH_DONE(I_HASH_DONE),
    .I_HASH_DIGEST(I_HASH_DIGEST), .O_SECRET_BANK(O_SECRET_BANK),
    .O_PROFILE_INDEX(O_PROFILE_INDEX), .I_SECRET(I_SECRET), .O_RSP_VALID(O_RSP_VALID),
    .O_RSP_LEN(O_RSP_LEN), .O_RSP_DATA(O_RSP_DATA), .O_SW1(O_SW1), .O_SW2(O_SW2));
  hash_partner partner (.i_clk(I_CLK_SYS), .i_nrst(I_NRST), .i_valid(O_HASH_VALID),
    .i_byte(O_HASH_BYTE), .i_first(O_HASH_FIRST), .i_finish(O_HASH_FINISH),
    .i_alg(O_HASH_ALG), .i_bank(O_SECRET_BANK), .i_index(O_PROFILE_INDEX),
    .o_ready(I_HASH_READY), .o_done(I_HASH_DONE), .o_digest(I_HASH_DIGEST),
    .o_secret(I_SECRET));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [127:0] hsh(input logic [7:0] q[$]);
    logic [127:0] a;
    a = '0;
    foreach (q[k])
      a = {a[119:0], a[127:120] ^ q[k]};
    return al ? ~a : a;
  endfunction
  function automatic void addw(input logic [127:0] s);
    for (int k = 0; k < 16; k++)
      eq.push_back(s[127 - 8 * k -: 8]);
  endfunction
  function automatic void addsec(input logic [1:0] b, input logic [7:0] i);
    addw({16{b, i[5:0]}});
  endfunction
  // Random bytes into both command data and expected stream
  function automatic void rdat(input int n);
    logic [7:0] b;
    repeat (n)
    begin
      b = 8'(rnd());
      dq.push_back(b);
      eq.push_back(b);
    end
  endfunction
  task automatic give_verdict();
    $display("Checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic push();
    foreach (dq[k])
    begin
      I_DATA_VALID <= 1'b1;
      I_DATA <= dq[k];
      do
      begin
        @(negedge I_CLK_SYS);
        if (!O_DATA_READY)
          full_seen = 1'b1;
      end
      while (!O_DATA_READY);
      @(posedge I_CLK_SYS);
    end
    I_DATA_VALID <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] cla, ins, p1, p2, e1, elen,
                     input logic [127:0] ed, input int lag);
    @(posedge I_CLK_SYS);
    fork
      begin
        repeat (lag) @(posedge I_CLK_SYS);
        I_CMD_VALID <= 1'b1;
        I_CLA <= cla;
        I_INS <= ins;
        I_P1 <= p1;
        I_P2 <= p2;
        I_LC <= 8'(dq.size());
        do @(negedge I_CLK_SYS); while (!O_CMD_READY);
        @(posedge I_CLK_SYS);
        I_CMD_VALID <= 1'b0;
      end
      push();
    join
    do @(negedge I_CLK_SYS); while (O_RSP_VALID !== 1'b1);
    `CHK("status1", e1, O_SW1)
    `CHK("status2", (e1 == SW1_SEQ) ? SW2_SEQ : SW2_NONE, O_SW2)
    `CHK("length", elen, O_RSP_LEN)
    `CHK("result", (elen == RSP_LEN_DIGEST) ? ed : 128'h0, O_RSP_DATA)
  endtask
  task automatic ip(input logic [7:0] p1, p2, e1, elen, input logic [127:0] ed);
    cmd(CLA_IP, INS_IP, p1, p2, e1, elen, ed, 0);
  endtask
  always @(posedge I_CLK_SYS)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end
  initial
  begin
    {I_NRST, I_CMD_VALID, I_DATA_VALID, I_HASH_ALG, al, full_seen} = '0;
    {I_CLA, I_INS, I_P1, I_P2, I_LC, I_DATA} = '0;
    repeat (4) @(posedge I_CLK_SYS);
    I_NRST <= 1'b1;
    repeat (2) @(posedge I_CLK_SYS);
    for (int t = 0; t < 4; t++)
    begin
      @(posedge I_CLK_SYS);
      al = 1'(rnd());
      I_HASH_ALG <= al;
      ix = 8'(rnd() % 8);
      id = 8'(rnd());
      dq = {id, ix};
      eq = {id};
      addsec(BANK_SIMPLE, ix);
      rdat((t == 0) ? 10 : t + 1);
      cmd(CLA_IP, INS_IP, P1_CHAP, P2_FIRST, SW1_OK, RSP_LEN_DIGEST, hsh(eq),
          (t == 0) ? 12 : 0);
    end
    `CHK("fifo_full", 1'b1, full_seen)
    dq = {id};
    eq = {id};
    addsec(BANK_HRPD, ix);
    rdat(4);
    ip(P1_HRPD, P2_FIRST, SW1_OK, RSP_LEN_DIGEST, hsh(eq));
    repeat (2)
    begin
      ix = 8'(rnd() % 8);
      dq = {ix};
      eq = {};
      addsec(BANK_HOME, ix);
      rdat(3);
      addsec(BANK_HOME, ix);
      ip(P1_HA, P2_SINGLE, SW1_OK, RSP_LEN_DIGEST, hsh(eq));
    end
    dq = {};
    eq = {};
    rdat(10);
    kept = hsh(eq);
    ip(P1_RRQ, P2_SINGLE, SW1_OK, RSP_LEN_NONE, '0);
    ix = 8'(rnd() % 8);
    dq = {ix};
    eq = {};
    rdat(1);
    addsec(BANK_AAA, ix);
    addw(kept);
    eq.push_back(dq[1]);
    rdat(3);
    ip(P1_AAA, P2_FIRST, SW1_OK, RSP_LEN_DIGEST, hsh(eq));
    dq = {ix, 8'h11};
    ip(P1_AAA, P2_FIRST, SW1_SEQ, RSP_LEN_NONE, '0);
    dq = {ix};
    eq = {};
    addsec(BANK_HOME, ix);
    rdat(2);
    ip(P1_HA, P2_FIRST, SW1_OK, RSP_LEN_NONE, '0);
    dq = {};
    rdat(3);
    ip(P1_HA, P2_NEXT, SW1_OK, RSP_LEN_NONE, '0);
    dq = {};
    rdat(2);
    addsec(BANK_HOME, ix);
    ip(P1_HA, P2_LAST, SW1_OK, RSP_LEN_DIGEST, hsh(eq));
    dq = {};
    rdat(2);
    ip(P1_HA, P2_NEXT, SW1_SEQ, RSP_LEN_NONE, '0);
    ip(P1_HA, P2_LAST, SW1_SEQ, RSP_LEN_NONE, '0);
    rdat(8);
    ip(P1_RRQ, P2_SINGLE, SW1_SEQ, RSP_LEN_NONE, '0);
    dq = {};
    cmd(8'ha0, INS_IP, P1_CHAP, P2_FIRST, SW1_CLA, RSP_LEN_NONE, '0, 0);
    cmd(CLA_IP, 8'ha4, P1_CHAP, P2_FIRST, SW1_INS, RSP_LEN_NONE, '0, 0);
    cmd(CLA_IP, INS_IP, 8'h05, P2_FIRST, SW1_PARAM, RSP_LEN_NONE, '0, 0);
    give_verdict();
  end
endmodule // tb_ip_auth_command_engine
